//--- include/aars_pkg.sv
// Shared constants and types for the converter alarm and reference control
package aars_pkg;
    // Status byte field positions
    localparam int STAT_DIFF_BIT    = 0;
    localparam int STAT_HIGH_BIT    = 1;
    localparam int STAT_LOW_BIT     = 2;
    localparam int STAT_REF_BIT     = 4;
    // Reference select field layout and mode register polarity bit
    localparam int POS_SEL_LSB      = 3;
    localparam int NEG_SEL_LSB      = 0;
    localparam int MODE_REGISTER_ZERO_REV_BIT    = 7;
    // Reset values
    localparam logic [5:0] REFSEL_RESET = 6'h00;
    localparam logic [7:0] MODE_REGISTER_ZERO_RESET  = 8'h00;
    localparam logic       INTERNAL_REFERENCE_ENABLE_RESET = 1'b1;
    // Modulator rate
    localparam int          MOD_DIV      = 8;
    localparam logic [2:0]  MOD_DIV_LAST = 3'(MOD_DIV - 1);
    // Reference select encodings
    localparam logic [2:0] SEL_INTERNAL = 3'h0;
    localparam logic [2:0] SEL_EXT0     = 3'h1;
    localparam logic [2:0] SEL_EXT1     = 3'h2;
    localparam logic [2:0] SEL_EXT2     = 3'h3;
    localparam logic [2:0] SEL_SUPPLY   = 3'h4;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONVERT
    } aars_state_t;
endpackage : aars_pkg

//--- include/aars_if.sv
// Link between alarm/reference device end and host end
interface aars_if
(
    input wire logic clock,
    input wire logic resetn
);
    logic       conv_start;
    logic       conv_done;
    logic [7:0] status_byte;
    logic       status_valid;
    logic [2:0] pos_reference_select;
    logic [2:0] neg_reference_select;
    logic [7:0] mode_register_zero;
    logic       internal_reference_enable;

    modport device
    (
        input  clock, resetn, conv_start, conv_done,
        input  pos_reference_select, neg_reference_select,
        input  mode_register_zero, internal_reference_enable,
        output status_byte, status_valid
    );
    modport host
    (
        input  clock, resetn, status_byte, status_valid,
        output conv_start, conv_done,
        output pos_reference_select, neg_reference_select,
        output mode_register_zero, internal_reference_enable
    );
endinterface : aars_if

//--- core/aars_device.sv
// Device end: alarm capture, reference routing and modulator rate
module aars_device
(
    // Link to host
    aars_if.device              link,
    // Analog comparator outputs (asynchronous)
    input  wire logic           cmp_diff_over,
    input  wire logic           cmp_amp_high,
    input  wire logic           cmp_amp_low,
    input  wire logic           cmp_ref_low,
    // Modulator raw bit
    input  wire logic           mod_bit_in,
    // Analog controls
    output logic [2:0]          pos_mux_onehot_sel,
    output logic [2:0]          neg_mux_onehot_sel,
    output logic                reference_polarity_invert,
    output logic                internal_reference_on,
    // Filter side
    output logic                mod_stream,
    output logic                mod_strobe
);
    logic [3:0] cmp_meta;
    logic [3:0] cmp_sync;
    logic [3:0] sticky;
    logic       active;
    logic [2:0] div_count;

    ////////////////////////////////////////////////////////////////////////
    // Comparators are asynchronous; first stage feeds only the second
    always_ff @(posedge link.clock or negedge link.resetn)
    begin
        if (!link.resetn)
        begin
            cmp_meta <= 4'h0;
            cmp_sync <= 4'h0;
        end
        else
        begin
            cmp_meta <= {cmp_ref_low, cmp_amp_low, cmp_amp_high,
                         cmp_diff_over};
            cmp_sync <= cmp_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge link.clock or negedge link.resetn)
    begin
        if (!link.resetn)
            active <= 1'b0;
        else if (link.conv_start)
            active <= 1'b1;
        else if (link.conv_done)
            active <= 1'b0;
    end

    // Start clears, so a cleared conversion never carries old events;
    // events seen on the start edge itself still win
    always_ff @(posedge link.clock or negedge link.resetn)
    begin
        if (!link.resetn)
            sticky <= 4'h0;
        else if (link.conv_start)
            sticky <= cmp_sync;
        else if (active)
            sticky <= sticky | cmp_sync;
    end

    always_ff @(posedge link.clock or negedge link.resetn)
    begin
        if (!link.resetn)
        begin
            link.status_byte  <= 8'h00;
            link.status_valid <= 1'b0;
        end
        else
        begin
            link.status_valid <= active && link.conv_done;
            if (active && link.conv_done)
            begin
                link.status_byte <= 8'h00;
                link.status_byte[aars_pkg::STAT_DIFF_BIT] <=
                    sticky[0] | cmp_sync[0];
                link.status_byte[aars_pkg::STAT_HIGH_BIT] <=
                    sticky[1] | cmp_sync[1];
                link.status_byte[aars_pkg::STAT_LOW_BIT] <=
                    sticky[2] | cmp_sync[2];
                link.status_byte[aars_pkg::STAT_REF_BIT] <=
                    sticky[3] | cmp_sync[3];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reference routing; unused encodings fall back to internal
    function automatic logic [2:0] decode_sel(input logic [2:0] sel);
        case (sel)
            aars_pkg::SEL_EXT0:   decode_sel = 3'h1;
            aars_pkg::SEL_EXT1:   decode_sel = 3'h2;
            aars_pkg::SEL_EXT2:   decode_sel = 3'h4;
            aars_pkg::SEL_SUPPLY: decode_sel = 3'h7;
            default:              decode_sel = 3'h0;
        endcase
    endfunction : decode_sel

    always_ff @(posedge link.clock or negedge link.resetn)
    begin
        if (!link.resetn)
        begin
            pos_mux_onehot_sel        <= 3'h0;
            neg_mux_onehot_sel        <= 3'h0;
            reference_polarity_invert <= 1'b0;
            internal_reference_on     <= aars_pkg::INTERNAL_REFERENCE_ENABLE_RESET;
        end
        else
        begin
            pos_mux_onehot_sel <=
                decode_sel(link.pos_reference_select);
            neg_mux_onehot_sel <=
                decode_sel(link.neg_reference_select);
            reference_polarity_invert <=
                link.mode_register_zero[aars_pkg::MODE_REGISTER_ZERO_REV_BIT];
            internal_reference_on <= link.internal_reference_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Modulator bit stream paced at clock / 8
    always_ff @(posedge link.clock or negedge link.resetn)
    begin
        if (!link.resetn)
        begin
            div_count  <= 3'h0;
            mod_strobe <= 1'b0;
            mod_stream <= 1'b0;
        end
        else
        begin
            mod_strobe <= (div_count == aars_pkg::MOD_DIV_LAST);
            div_count  <= (div_count == aars_pkg::MOD_DIV_LAST) ?
                          3'h0 : div_count + 3'h1;
            if (div_count == aars_pkg::MOD_DIV_LAST)
                mod_stream <= mod_bit_in;
        end
    end
endmodule : aars_device

//--- core/aars_host.sv
// Host end: sequences conversions and holds reference configuration
module aars_host
(
    // Link to device
    aars_if.host                link,
    // User side
    input  wire logic           user_start,
    input  wire logic           user_stop,
    input  wire logic           cfg_write,
    input  wire logic [2:0]     cfg_pos_select,
    input  wire logic [2:0]     cfg_neg_select,
    input  wire logic [7:0]     cfg_mode_zero,
    input  wire logic           cfg_internal_reference_enable_enable,
    input  wire logic           ref_ready,
    output logic [7:0]          user_status,
    output logic                user_status_valid,
    output logic                user_busy
);
    aars_pkg::aars_state_t state;

    ////////////////////////////////////////////////////////////////////////
    // Polarity forced normal when internal or supply is chosen as the positive reference
    always_ff @(posedge link.clock or negedge link.resetn)
    begin
        if (!link.resetn)
        begin
            link.pos_reference_select      <= aars_pkg::REFSEL_RESET[5:3];
            link.neg_reference_select      <= aars_pkg::REFSEL_RESET[2:0];
            link.mode_register_zero        <= aars_pkg::MODE_REGISTER_ZERO_RESET;
            link.internal_reference_enable <= aars_pkg::INTERNAL_REFERENCE_ENABLE_RESET;
        end
        else if (cfg_write && state == aars_pkg::ST_IDLE)
        begin
            link.pos_reference_select <= cfg_pos_select;
            link.neg_reference_select <= cfg_neg_select;
            link.mode_register_zero   <= cfg_mode_zero;
            if (cfg_pos_select == aars_pkg::SEL_INTERNAL ||
                cfg_pos_select == aars_pkg::SEL_SUPPLY)
                link.mode_register_zero[aars_pkg::MODE_REGISTER_ZERO_REV_BIT] <=
                    1'b0;
            // Sensor and excitation users need the reference kept on
            link.internal_reference_enable <= cfg_internal_reference_enable_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge link.clock or negedge link.resetn)
    begin
        if (!link.resetn)
        begin
            state           <= aars_pkg::ST_IDLE;
            link.conv_start <= 1'b0;
            link.conv_done  <= 1'b0;
            user_busy       <= 1'b0;
        end
        else
        begin
            link.conv_start <= 1'b0;
            link.conv_done  <= 1'b0;
            case (state)
                aars_pkg::ST_IDLE:
                    if (user_start && ref_ready)
                    begin
                        link.conv_start <= 1'b1;
                        user_busy       <= 1'b1;
                        state           <= aars_pkg::ST_CONVERT;
                    end
                aars_pkg::ST_CONVERT:
                    if (user_stop)
                    begin
                        link.conv_done <= 1'b1;
                        user_busy      <= 1'b0;
                        state          <= aars_pkg::ST_IDLE;
                    end
                default:
                    state <= aars_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge link.clock or negedge link.resetn)
    begin
        if (!link.resetn)
        begin
            user_status       <= 8'h00;
            user_status_valid <= 1'b0;
        end
        else
        begin
            user_status_valid <= link.status_valid;
            if (link.status_valid)
                user_status <= link.status_byte;
        end
    end
endmodule : aars_host

//--- testbench/aars_checker.sv
// Checker on the link between the device end and the host end
module aars_checker
(
    // Link signals
    input wire logic       clock,
    input wire logic       resetn,
    input wire logic       conv_start,
    input wire logic       conv_done,
    input wire logic [7:0] status_byte,
    input wire logic       status_valid,
    input wire logic [2:0] pos_reference_select,
    input wire logic [7:0] mode_register_zero
);
    timeunit 1ns;
    timeprecision 1ps;
    logic in_conv;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            in_conv <= 1'b0;
        else if (conv_start)
            in_conv <= 1'b1;
        else if (conv_done)
            in_conv <= 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    a_valid_after_done:
        assert property (conv_done |=> status_valid)
        else $error("status not flagged after done");
    a_valid_has_cause:
        assert property (status_valid |-> $past(conv_done))
        else $error("status flagged without done");
    a_status_holds:
        assert property (!status_valid |-> $stable(status_byte))
        else $error("status byte changed between conversions");
    a_spare_bits_zero:
        assert property (status_valid |-> status_byte[7:5] == 3'h0
                         && !status_byte[3])
        else $error("spare status bits set");
    a_polarity_safe:
        assert property ((pos_reference_select == 3'h0
                          || pos_reference_select == 3'h4)
                         |-> !mode_register_zero[7])
        else $error("polarity invert with internal or supply");
    a_start_one_cycle:
        assert property (conv_start |=> !conv_start)
        else $error("start longer than one cycle");
    a_valid_one_cycle:
        assert property (status_valid |=> !status_valid)
        else $error("status flag longer than one cycle");
    a_done_in_conv:
        assert property (conv_done |-> in_conv && !conv_start)
        else $error("done outside a conversion");
    c_alarm_seen: cover property (status_valid && status_byte != 8'h00);
    c_ref_alarm: cover property (status_valid && status_byte[4]);
    c_ext_select: cover property (pos_reference_select == 3'h2);
endmodule : aars_checker

//--- testbench/adc_alarm_and_reference_select_tb.sv
// Self-checking bench joining the device end and the host end
module adc_alarm_and_reference_select_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clock, resetn, mod_bit_in, ref_ready, cfg_write, cfg_ie;
    logic       user_start, user_stop, user_status_valid, user_busy;
    logic       pol, ion, mod_stream, mod_strobe, bit_prev;
    logic [3:0] cmp;
    logic [2:0] cfg_pos, cfg_neg, pos_oh, neg_oh;
    logic [7:0] cfg_mode, user_status;
    logic [7:0] exp_q[$];
    int         mismatches, cmp_count, cycles, gap;
    ////////////////////////////////////////////////////////////////////////
    aars_if aars_if_i (.clock(clock), .resetn(resetn));
    aars_device aars_device_i (.link(aars_if_i), .cmp_diff_over(cmp[0]),
        .cmp_amp_high(cmp[1]), .cmp_amp_low(cmp[2]), .cmp_ref_low(cmp[3]),
        .mod_bit_in(mod_bit_in), .pos_mux_onehot_sel(pos_oh),
        .neg_mux_onehot_sel(neg_oh), .reference_polarity_invert(pol),
        .internal_reference_on(ion), .mod_stream(mod_stream),
        .mod_strobe(mod_strobe));
    aars_host aars_host_i (.link(aars_if_i), .user_start(user_start),
        .user_stop(user_stop), .cfg_write(cfg_write), .cfg_pos_select(cfg_pos),
        .cfg_neg_select(cfg_neg), .cfg_mode_zero(cfg_mode),
        .cfg_internal_reference_enable_enable(cfg_ie), .ref_ready(ref_ready),
        .user_status(user_status), .user_status_valid(user_status_valid),
        .user_busy(user_busy));
    aars_checker aars_checker_i (.clock(clock), .resetn(resetn),
        .conv_start(aars_if_i.conv_start), .conv_done(aars_if_i.conv_done),
        .status_byte(aars_if_i.status_byte),
        .status_valid(aars_if_i.status_valid),
        .pos_reference_select(aars_if_i.pos_reference_select),
        .mode_register_zero(aars_if_i.mode_register_zero));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    function automatic logic [2:0] onehot(input logic [2:0] s);
        return s == 3'h1 ? 3'h1 : s == 3'h2 ? 3'h2 : s == 3'h3 ? 3'h4 :
               s == 3'h4 ? 3'h7 : 3'h0;
    endfunction : onehot
    task automatic configure(input logic [2:0] p, input logic [2:0] q,
                             input logic [7:0] m, input logic ie);
        cfg_pos <= p;
        cfg_neg <= q;
        cfg_mode <= m;
        cfg_ie <= ie;
        cfg_write <= 1'b1;
        @(posedge clock);
        cfg_write <= 1'b0;
        repeat (3) @(posedge clock);
        check(8'(pos_oh), 8'(onehot(p)));
        check(8'(neg_oh), 8'(onehot(q)));
        check(8'(pol), 8'(m[7] && p != 3'h0 && p != 3'h4));
        check(8'(ion), 8'(ie));
    endtask : configure
    // Idle alarms come first: they must not leak into the next status
    task automatic convert(input logic [3:0] pat);
        repeat (4) @(posedge clock);
        cmp <= 4'hf;
        repeat (2) @(posedge clock);
        cmp <= 4'h0;
        repeat (6) @(posedge clock);
        user_start <= 1'b1;
        @(posedge clock);
        user_start <= 1'b0;
        repeat (3) @(posedge clock);
        check(8'(user_busy), 8'h01);
        cmp <= pat;
        repeat (3) @(posedge clock);
        cmp <= 4'h0;
        repeat (4) @(posedge clock);
        exp_q.push_back({3'h0, pat[3], 1'b0, pat[2:0]});
        user_stop <= 1'b1;
        @(posedge clock);
        user_stop <= 1'b0;
        repeat (4) @(posedge clock);
    endtask : convert
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles++;
        mod_bit_in <= 1'($urandom);
        if (user_status_valid === 1'b1)
            check(user_status, exp_q.size() ? exp_q.pop_front() : 8'hxx);
        if (resetn && mod_strobe === 1'b1)
        begin
            if (gap > 0)
                check(8'(gap), 8'h08);
            // Stream bit was loaded from the input seen one edge earlier
            check(8'(mod_stream), 8'(bit_prev));
            gap = 1;
        end
        else if (gap > 0)
            gap++;
        bit_prev = mod_bit_in;
        if (cycles == 20000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end
    initial
    begin
        {resetn, cmp, mod_bit_in, cfg_write, cfg_ie} = '0;
        {user_start, user_stop, cfg_pos, cfg_neg, cfg_mode} = '0;
        ref_ready = 1'b1;
        void'($urandom(90634));
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        check(8'(ion), 8'h01);
        check(8'({pos_oh, neg_oh}), 8'h00);
        $display("reset test done");
        for (int i = 0; i < 8; i++)
            configure(3'(i), 3'(7 - i), 8'h80 | 8'($urandom), i[0]);
        configure(3'h0, 3'h0, 8'h80, 1'b1);
        $display("config test done");
        ref_ready <= 1'b0;
        user_start <= 1'b1;
        @(posedge clock);
        user_start <= 1'b0;
        repeat (3) @(posedge clock);
        check(8'(user_busy), 8'h00);
        ref_ready <= 1'b1;
        for (int i = 0; i < 24; i++)
            convert(i < 16 ? 4'(i) : 4'($urandom));
        check(8'(exp_q.size()), 8'h00);
        $display("conversion test done");
        tally_and_finish();
    end
endmodule : adc_alarm_and_reference_select_tb
